// >>> hdl/timer16_map.vh
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_COUNT_LOW     8'h00
`define OFS_COUNT_HIGH    8'h04
`define OFS_CONTROL       8'h08
`define OFS_FLAGS         8'h0C
`define OFS_CMP_ONE       8'h10
`define OFS_CMP_TWO       8'h14
`define OFS_CMP_MODES     8'h18

// ****************************************************************
// control and flag register fields
// ****************************************************************
`define BIT_COUNTER_ON    0
`define BIT_CLOCK_SOURCE  1
`define BIT_SYNC_BYPASS   2
`define BIT_OSC_ENABLE    3
`define BIT_PRESCALE_LO   4
`define BIT_PRESCALE_HI   5
`define BIT_OVERFLOW      0

// ****************************************************************
// reset values and codes
// ****************************************************************
`define CONTROL_RESET     6'h00
`define COUNT_WRAP        16'hFFFF
`define COUNT_ZERO        16'h0000
`define TRIGGER_MODE      4'hB
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ****************************************************************
// phase clock timing: four core clock periods per instruction
// ****************************************************************
`define PHASE_TWO_CODE    2'h1
`define PHASE_FOUR_CODE   2'h3

`endif

// >>> hdl/sync_filter.v
`timescale 1ns/100ps
module sync_filter #(
  parameter W = 2
) (
  input  wire         ref_clk,   // core clock
  input  wire         rstn,      // async reset, active low
  input  wire [W-1:0] pinIn,     // asynchronous inputs
  output reg  [W-1:0] levelOut   // filtered synchronous levels
);

  reg [W-1:0] stageOne;
  reg [W-1:0] stageTwo;
  reg [W-1:0] stageThree;

  // three flops; a change counts once stages two and three agree
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stageOne   <= {W{1'b0}};
      stageTwo   <= {W{1'b0}};
      stageThree <= {W{1'b0}};
      levelOut   <= {W{1'b0}};
    end else begin
      stageOne   <= pinIn;
      stageTwo   <= stageOne;
      stageThree <= stageTwo;
      // agreeing stages give the new level; a split keeps the old one
      levelOut   <= (stageTwo & stageThree) |
                    (levelOut & (stageTwo ^ stageThree));
    end
  end

endmodule // sync_filter

// >>> hdl/timer16.v
// Overview of operation
// - count 0000h..FFFFh, wrap, latch overflow flag
// - internal counts instruction cycles, external counts edges
// - sync mode in sleep: no count, prescaler runs
// - count byte writes clear prescaler
// - 1:1 sync samples at phase two, four
// - counter updates two cycles after sampling edge
// - other ratios use symmetrical ripple prescaler
// - bypass bit counts without phase synchronisation
// - async mode counts in sleep, flags wake
// - async mode gives no compare time base
// - byte reads are always stable
// - oscillator enable starts oscillator, runs in sleep
// - trigger mode 1011 compare event clears count
// - trigger clear never sets overflow flag
// - count write wins over coincident trigger; here a trigger still pending in the next cycle clears the written count
// - compare value acts as counting period
// - no reset clears the count bytes
// - power-on reset clears control register
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "timer16_map.vh"
module timer16 (
  input  wire        ref_clk,         // 25 MHz core clock
  input  wire        rstn,            // power-on/brown-out reset, low
  input  wire        sleepMode,       // core is asleep
  input  wire        extCountPin,     // external count clock pin
  input  wire        oscInPin,        // low-power oscillator input
  output reg         oscEnable,       // runs the low-power oscillator
  output reg         overflowFlag,    // sticky overflow flag
  output reg         timeBaseValid,   // count usable by compare units
  output reg  [15:0] timeBase,        // count copy for compare units
  input  wire [7:0]  s_axi_awaddr,    // write address
  input  wire        s_axi_awvalid,   // write address valid
  output reg         s_axi_awready,   // write address ready
  input  wire [31:0] s_axi_wdata,     // write data
  input  wire [3:0]  s_axi_wstrb,     // write byte strobes
  input  wire        s_axi_wvalid,    // write data valid
  output reg         s_axi_wready,    // write data ready
  output reg  [1:0]  s_axi_bresp,     // write response
  output reg         s_axi_bvalid,    // write response valid
  input  wire        s_axi_bready,    // write response ready
  input  wire [7:0]  s_axi_araddr,    // read address
  input  wire        s_axi_arvalid,   // read address valid
  output reg         s_axi_arready,   // read address ready
  output reg  [31:0] s_axi_rdata,     // read data
  output reg  [1:0]  s_axi_rresp,     // read response
  output reg         s_axi_rvalid,    // read data valid
  input  wire        s_axi_rready     // read data ready
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg  [1:0]  phaseCnt;
  reg  [5:0]  control;
  reg  [15:0] count;
  reg  [15:0] cmpOne;
  reg  [15:0] cmpTwo;
  reg  [7:0]  cmpModes;
  reg  [2:0]  prescaler;
  reg         srcPrev;
  reg         prescPrev;
  reg         syncSample;
  reg         syncPrev;
  reg         syncTick;
  reg         triggerPend;
  reg         awHeld;
  reg         wHeld;
  reg  [7:0]  awAddr;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg  [15:0] next_count;
  reg         next_wrap;
  wire [1:0]  pinLevel;
  wire        counterOn;
  wire        extSource;
  wire        syncBypass;
  wire [1:0]  prescSel;
  wire        asyncMode;
  wire        instrTick;
  wire        extLevel;
  wire        srcLevel;
  wire        srcEdge;
  wire        prescOut;
  wire        prescRise;
  wire        incTick;
  wire        wrEn;
  wire        wrLow;
  wire        wrHigh;
  wire        triggerHit;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // true when the byte address names a register
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `OFS_COUNT_LOW) || (addr == `OFS_COUNT_HIGH) ||
               (addr == `OFS_CONTROL) || (addr == `OFS_FLAGS) ||
               (addr == `OFS_CMP_ONE) || (addr == `OFS_CMP_TWO) ||
               (addr == `OFS_CMP_MODES);
    end
  endfunction

  // merge byte lanes of a write into an old 16-bit value
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8],
                 strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  sync_filter #(.W(2)) u_pins (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .pinIn    ({oscInPin, extCountPin}),
    .levelOut (pinLevel)
  );

  // ****************************************************************
  // control decode
  // ****************************************************************
  assign counterOn  = control[`BIT_COUNTER_ON];
  assign extSource  = control[`BIT_CLOCK_SOURCE];
  assign syncBypass = control[`BIT_SYNC_BYPASS];
  assign prescSel   = control[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO];
  assign asyncMode  = extSource & syncBypass;
  // oscillator input replaces the pin while the oscillator runs
  assign extLevel   = control[`BIT_OSC_ENABLE] ? pinLevel[1] : pinLevel[0];

  // ****************************************************************
  // phase clocks: four core periods per instruction cycle
  // ****************************************************************
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phaseCnt <= 2'h0;
    end else begin
      phaseCnt <= phaseCnt + 2'h1;
    end
  end

  // the instruction clock stops while the core sleeps
  assign instrTick = (phaseCnt == `PHASE_FOUR_CODE) & ~sleepMode;

  // ****************************************************************
  // prescaler: ripple-style divider on the selected source
  // ****************************************************************
  assign srcLevel = extSource ? extLevel : 1'b0;
  assign srcEdge  = extSource ? (srcLevel & ~srcPrev) : instrTick;

  // prescaler keeps counting external edges in sleep
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prescaler <= 3'h0;
      srcPrev   <= 1'b0;
    end else begin
      srcPrev <= srcLevel;
      if (wrLow | wrHigh) begin
        prescaler <= 3'h0;
      end else if (srcEdge) begin
        prescaler <= prescaler + 3'h1;
      end
    end
  end

  // each divider bit is a symmetrical square wave
  assign prescOut = (prescSel == 2'h0) ? srcLevel :
                    (prescSel == 2'h1) ? prescaler[0] :
                    (prescSel == 2'h2) ? prescaler[1] :
                                         prescaler[2];
  assign prescRise = (prescSel == 2'h0) ? srcEdge :
                     (prescOut & ~prescPrev);

  // ****************************************************************
  // phase synchroniser and delayed increment
  // ****************************************************************
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prescPrev  <= 1'b0;
      syncSample <= 1'b0;
      syncPrev   <= 1'b0;
      syncTick   <= 1'b0;
    end else begin
      prescPrev <= prescOut;
      // sampling at phase two and four; shut off in sleep
      if (((phaseCnt == `PHASE_TWO_CODE) ||
           (phaseCnt == `PHASE_FOUR_CODE)) && !sleepMode) begin
        syncSample <= prescOut;
      end
      syncPrev <= syncSample;
      // increment lands two cycles after the sampling clock edge
      syncTick <= syncSample & ~syncPrev;
    end
  end

  // timer mode ticks per prescaled instruction; async counts prescaled edges unsynchronised
  assign incTick = counterOn &
                   (!extSource ? prescRise :
                    asyncMode  ? prescRise :
                                 syncTick);

  // ****************************************************************
  // compare special event trigger
  // ****************************************************************
  // no time base in async mode, so no match there either
  assign triggerHit = ~asyncMode &
    (((cmpModes[3:0] == `TRIGGER_MODE) && (count == cmpOne)) ||
     ((cmpModes[7:4] == `TRIGGER_MODE) && (count == cmpTwo)));

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      triggerPend <= 1'b0;
    end else begin
      triggerPend <= triggerHit;
    end
  end

  // ****************************************************************
  // count next value
  // ****************************************************************
  assign wrEn   = awHeld & wHeld & ~s_axi_bvalid;
  assign wrLow  = wrEn & (awAddr == `OFS_COUNT_LOW) & wStrb[0];
  assign wrHigh = wrEn & (awAddr == `OFS_COUNT_HIGH) & wStrb[0];

  always @* begin
    next_count = count;
    next_wrap  = 1'b0;
    if (wrLow | wrHigh) begin
      // a write takes precedence over a coincident trigger
      if (wrLow) begin
        next_count[7:0] = wData[7:0];
      end
      if (wrHigh) begin
        next_count[15:8] = wData[7:0];
      end
    end else if (triggerPend) begin
      next_count = `COUNT_ZERO;
    end else if (incTick) begin
      next_count = count + 16'h0001;
      next_wrap  = (count == `COUNT_WRAP);
    end
  end

  // count has no reset at all
  always @(posedge ref_clk) begin
    count <= next_count;
  end

  // ****************************************************************
  // control, compare and flag registers
  // ****************************************************************
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      control      <= `CONTROL_RESET;
      cmpOne       <= 16'h0000;
      cmpTwo       <= 16'h0000;
      cmpModes     <= 8'h00;
      overflowFlag <= 1'b0;
      oscEnable    <= 1'b0;
      timeBase     <= 16'h0000;
      timeBaseValid <= 1'b0;
    end else begin
      if (wrEn && (awAddr == `OFS_CONTROL) && wStrb[0]) begin
        control <= wData[5:0];
      end
      if (wrEn && (awAddr == `OFS_CMP_ONE)) begin
        cmpOne <= merge16(cmpOne, wData, wStrb);
      end
      if (wrEn && (awAddr == `OFS_CMP_TWO)) begin
        cmpTwo <= merge16(cmpTwo, wData, wStrb);
      end
      if (wrEn && (awAddr == `OFS_CMP_MODES) && wStrb[0]) begin
        cmpModes <= wData[7:0];
      end
      // write one clears; a wrap in the same cycle wins
      if (next_wrap) begin
        overflowFlag <= 1'b1;
      end else if (wrEn && (awAddr == `OFS_FLAGS) && wStrb[0] &&
                   wData[`BIT_OVERFLOW]) begin
        overflowFlag <= 1'b0;
      end
      oscEnable     <= control[`BIT_OSC_ENABLE];
      timeBase      <= count;
      timeBaseValid <= counterOn & ~asyncMode;
    end
  end

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr        <= s_axi_awaddr;
        awHeld        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        wHeld        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrEn) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr) ? `RESP_OKAY : `RESP_SLVERR;
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // axi4-lite read channel; single clock keeps bytes stable
  // ****************************************************************
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
          `OFS_COUNT_LOW:  s_axi_rdata <= {24'h000000, count[7:0]};
          `OFS_COUNT_HIGH: s_axi_rdata <= {24'h000000, count[15:8]};
          `OFS_CONTROL:    s_axi_rdata <= {26'h0000000, control};
          `OFS_FLAGS:      s_axi_rdata <= {31'h00000000, overflowFlag};
          `OFS_CMP_ONE:    s_axi_rdata <= {16'h0000, cmpOne};
          `OFS_CMP_TWO:    s_axi_rdata <= {16'h0000, cmpTwo};
          `OFS_CMP_MODES:  s_axi_rdata <= {24'h000000, cmpModes};
          default:         s_axi_rdata <= 32'h00000000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // timer16

// >>> verif/timer16_assertions.sv
`timescale 1ns/100ps
`include "timer16_map.vh"
module timer16_assertions (
  input wire        ref_clk,       // clock
  input wire        rstn,          // reset
  input wire        sleepMode,     // sleep
  input wire        oscEnable,     // osc run
  input wire        overflowFlag,  // flag
  input wire        timeBaseValid, // base ok
  input wire [15:0] timeBase,      // count copy
  input wire [7:0]  s_axi_awaddr,  // aw addr
  input wire        s_axi_awvalid, // aw valid
  input wire        s_axi_awready, // aw ready
  input wire [31:0] s_axi_wdata,   // w data
  input wire        s_axi_wvalid,  // w valid
  input wire        s_axi_wready,  // w ready
  input wire        s_axi_bvalid,  // b valid
  input wire        s_axi_bready   // b ready
);
  // ****
  // write tracking
  // ****
  reg  [7:0]  wAddr;
  reg  [31:0] wData;
  reg  [5:0]  ctrl;
  reg  [3:0]  sleepCnt;
  wire        asyncMode = ctrl[1] && ctrl[2];

  // address and data of the write, control copy, sleep length
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wAddr    <= 8'h00;
      wData    <= 32'h0;
      ctrl     <= 6'h00;
      sleepCnt <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready)
        wAddr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        wData <= s_axi_wdata;
      if (s_axi_bvalid && s_axi_bready && wAddr == `OFS_CONTROL)
        ctrl <= wData[5:0];
      if (!sleepMode)
        sleepCnt <= 4'h0;
      else if (sleepCnt != 4'hF)
        sleepCnt <= sleepCnt + 4'h1;
    end
  end

  // ****
  // checks
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_commit;
    s_axi_bvalid && !$past(s_axi_bvalid);
  endsequence
  property p_reset_ctrl;
    $rose(rstn) |-> !oscEnable && !timeBaseValid && !overflowFlag;
  endproperty
  property p_osc_follow;
    s_commit ##0 wAddr == `OFS_CONTROL |-> ##2 (oscEnable == ctrl[3]) [*2];
  endproperty
  property p_base_valid;
    s_commit ##0 wAddr == `OFS_CONTROL
      |-> ##2 timeBaseValid == (ctrl[0] && !asyncMode);
  endproperty
  property p_ovf_cause;
    $rose(overflowFlag) |-> timeBase == `COUNT_WRAP;
  endproperty
  property p_ovf_clear;
    $fell(overflowFlag) |-> s_commit ##0 wAddr == `OFS_FLAGS;
  endproperty
  property p_count_step;
    $past(rstn, 2) && $changed(timeBase) && !s_axi_bvalid &&
      !$past(s_axi_bvalid)
      |-> timeBase == $past(timeBase) + 16'h1 || timeBase == `COUNT_ZERO;
  endproperty
  property p_sleep_hold;
    sleepCnt > 4'h5 && !asyncMode |-> $stable(timeBase);
  endproperty
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid && !s_axi_awready;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl)
    else $error("state not cleared by reset");
  a_osc_follow: assert property (p_osc_follow)
    else $error("oscillator enable does not follow control");
  a_base_valid: assert property (p_base_valid)
    else $error("time base valid wrong for mode");
  a_ovf_cause: assert property (p_ovf_cause)
    else $error("overflow flag set without wrap");
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow flag lost without clear write");
  a_count_step: assert property (p_count_step)
    else $error("count moved by other than one");
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("synchronised count moved in sleep");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");
  c_overflow: cover property ($rose(overflowFlag));
  c_async_sleep: cover property (sleepCnt == 4'hF && $changed(timeBase));
  c_trigger: cover property (timeBase == 16'h0 && $past(timeBase) == 16'h10);
endmodule // timer16_assertions

bind timer16 timer16_assertions i_timer16_assertions (
  .ref_clk(ref_clk), .rstn(rstn), .sleepMode(sleepMode),
  .oscEnable(oscEnable), .overflowFlag(overflowFlag),
  .timeBaseValid(timeBaseValid), .timeBase(timeBase),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready)
);

// >>> verif/count_clock_source.sv
`timescale 1ns/100ps
// ****
// external count clock source
// ****
module count_clock_source #(
  parameter HALF_NS = 170  // level time, not a multiple of the core period
) (
  input  wire       startReq, // burst request
  input  wire [7:0] nPulses,  // pulses in burst
  input  wire       viaOsc,   // use crystal pin
  output reg        extPin,   // count clock pin
  output reg        oscPin,   // crystal pin
  output reg        busy      // burst running
);
  integer i;
  // clock stands low between bursts
  initial begin
    extPin = 1'b0;
    oscPin = 1'b0;
    busy   = 1'b0;
  end
  // each level lasts well over two core periods
  always @(posedge startReq) begin
    busy = 1'b1;
    for (i = 0; i < nPulses; i = i + 1) begin
      #(HALF_NS);
      if (viaOsc) oscPin = 1'b1;
      else extPin = 1'b1;
      #(HALF_NS);
      oscPin = 1'b0;
      extPin = 1'b0;
    end
    #(HALF_NS);
    busy = 1'b0;
  end
endmodule // count_clock_source

// >>> verif/tb_timer16.sv
`timescale 1ns/100ps
`include "timer16_map.vh"
module tb_timer16;
  reg         ref_clk, rstn, sleepMode, awvalid, wvalid, bready;
  reg         arvalid, rready, startReq, viaOsc;
  reg  [7:0]  awaddr, araddr, nPulses;
  reg  [31:0] wdata, lfsr, d;
  reg  [15:0] c, st;
  reg  [1:0]  r;
  wire        awready, wready, bvalid, arready, rvalid, extPin, oscPin;
  wire        srcBusy, oscEnable, overflowFlag, timeBaseValid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] timeBase;
  integer     n_mismatch, compares, k;

  // ****
  // design and far side
  // ****
  timer16 i_timer16 (
    .ref_clk(ref_clk), .rstn(rstn), .sleepMode(sleepMode),
    .extCountPin(extPin), .oscInPin(oscPin), .oscEnable(oscEnable),
    .overflowFlag(overflowFlag), .timeBaseValid(timeBaseValid),
    .timeBase(timeBase), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  count_clock_source i_count_clock_source (
    .startReq(startReq), .nPulses(nPulses), .viaOsc(viaOsc),
    .extPin(extPin), .oscPin(oscPin), .busy(srcBusy)
  );

  // ****
  // helpers
  // ****
  function [31:0] nextRand(input [31:0] s);
    nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task complete_run;
    begin
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  task timedOut;
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t wait got %h exp %h", $time, 32'h0, 32'h1);
      complete_run;
    end
  endtask

  // compare, with a tolerance of one where phase alignment is free
  task check(input [31:0] got, input [31:0] exp, input tol);
    begin
      compares = compares + 1;
      if (got !== exp && !(tol && (got === exp + 1 || got + 1 === exp))) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task axiWr(input [7:0] a, input [31:0] v, output [1:0] rs);
    integer i;
    begin
      @(posedge ref_clk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      rs = 2'h3;
      for (i = 0; i < 40 && rs == 2'h3; i = i + 1) begin
        @(posedge ref_clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          rs = bresp;
          bready <= 1'b0;
        end
      end
      if (rs == 2'h3) timedOut;
    end
  endtask

  task axiRd(input [7:0] a, output [31:0] v, output [1:0] rs);
    integer i;
    begin
      @(posedge ref_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      rs = 2'h3;
      for (i = 0; i < 40 && rs == 2'h3; i = i + 1) begin
        @(posedge ref_clk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          v = rdata;
          rs = rresp;
          rready <= 1'b0;
        end
      end
      if (rs == 2'h3) timedOut;
    end
  endtask

  task wrCount(input [15:0] v);
    begin
      axiWr(`OFS_COUNT_LOW, {24'h0, v[7:0]}, r);
      axiWr(`OFS_COUNT_HIGH, {24'h0, v[15:8]}, r);
    end
  endtask

  // high, low, high; low again if the high byte moved
  task rdCount(output [15:0] v);
    reg [31:0] h1, lo, h2;
    begin
      axiRd(`OFS_COUNT_HIGH, h1, r);
      axiRd(`OFS_COUNT_LOW, lo, r);
      axiRd(`OFS_COUNT_HIGH, h2, r);
      if (h1[7:0] !== h2[7:0]) axiRd(`OFS_COUNT_LOW, lo, r);
      v = {h2[7:0], lo[7:0]};
    end
  endtask

  // count a burst from the far side, stopped counter read back
  task runExt(input [7:0] ct, input s, input o, input [7:0] n,
              input [15:0] e, input t);
    integer i;
    begin
      axiWr(`OFS_CONTROL, {24'h0, ct & 8'hFE}, r);
      repeat (8) @(posedge ref_clk);
      wrCount(16'h0000);
      sleepMode <= s;
      axiWr(`OFS_CONTROL, {24'h0, ct}, r);
      repeat (3) @(posedge ref_clk);
      check(timeBaseValid, !(ct[1] && ct[2]), 0);
      viaOsc   <= o;
      nPulses  <= n;
      startReq <= 1'b1;
      @(posedge ref_clk);
      startReq <= 1'b0;
      for (i = 0; (srcBusy !== 1'b0 || i < 2) && i < 1000; i = i + 1)
        @(posedge ref_clk);
      if (i == 1000) timedOut;
      repeat (20) @(posedge ref_clk);
      axiWr(`OFS_CONTROL, {24'h0, ct & 8'hFE}, r);
      sleepMode <= 1'b0;
      rdCount(c);
      check(c, e, t);
      $display("done: burst with control %h", ct);
    end
  endtask

  // ****
  // sequence
  // ****
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    rstn = 1'b0;
    sleepMode = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, startReq, viaOsc} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    nPulses = 8'h00;
    wdata = 32'h0;
    lfsr = 32'h75F0;
    n_mismatch = 0;
    compares = 0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    axiRd(`OFS_CONTROL, d, r);
    check(d, 32'h0, 0);
    axiRd(8'h1C, d, r);
    check(r, `RESP_SLVERR, 0);
    check(d, 32'h0, 0);
    axiWr(8'h20, 32'hFF, r);
    check(r, `RESP_SLVERR, 0);
    $display("done: reset and map");
    for (k = 0; k < 4; k = k + 1) begin
      lfsr = nextRand(lfsr);
      st = {4'h0, lfsr[11:0]};
      wrCount(st);
      axiWr(`OFS_CONTROL, (k << 4) | 1, r);
      repeat (256) @(posedge ref_clk);
      axiWr(`OFS_CONTROL, k << 4, r);
      rdCount(c);
      check(c, st + 260 / (4 << k), 1);
    end
    axiWr(`OFS_CONTROL, 32'h31, r);
    repeat (10) wrCount(16'h1234);
    axiWr(`OFS_CONTROL, 32'h30, r);
    rdCount(c);
    check(c, 16'h1234, 0);
    $display("done: prescale");
    wrCount(16'hFFFC);
    axiWr(`OFS_CONTROL, 32'h01, r);
    for (k = 0; k < 100 && overflowFlag !== 1'b1; k = k + 1)
      @(posedge ref_clk);
    if (k == 100) timedOut;
    axiWr(`OFS_CONTROL, 32'h00, r);
    rdCount(c);
    check(c < 16'h0010, 1'b1, 0);
    axiRd(`OFS_FLAGS, d, r);
    check(d, 32'h1, 0);
    axiWr(`OFS_FLAGS, 32'h1, r);
    axiRd(`OFS_FLAGS, d, r);
    check(d, 32'h0, 0);
    $display("done: overflow");
    for (k = 0; k < 2; k = k + 1) begin
      axiWr(k ? `OFS_CMP_TWO : `OFS_CMP_ONE, 32'h10, r);
      axiWr(`OFS_CMP_MODES, k ? {24'h0, `TRIGGER_MODE, 4'h0}
                              : {28'h0, `TRIGGER_MODE}, r);
      wrCount(16'h0000);
      axiWr(`OFS_CONTROL, 32'h01, r);
      repeat (200) @(posedge ref_clk);
      axiWr(`OFS_CONTROL, 32'h00, r);
      rdCount(c);
      check(c <= 16'h0010, 1'b1, 0);
      check(overflowFlag, 1'b0, 0);
    end
    axiWr(`OFS_CMP_MODES, 32'h0, r);
    $display("done: trigger clear");
    lfsr = nextRand(lfsr);
    k = 5 + lfsr[3:0];
    runExt(8'h03, 1'b0, 1'b0, k, k, 1'b0);
    runExt(8'h23, 1'b0, 1'b0, 8'd16, 16'h4, 1'b1);
    runExt(8'h03, 1'b1, 1'b0, 8'd10, 16'h0, 1'b0);
    runExt(8'h07, 1'b1, 1'b0, 8'd10, 16'hA, 1'b0);
    runExt(8'h0B, 1'b0, 1'b1, 8'd12, 16'hC, 1'b0);
    complete_run;
  end
endmodule // tb_timer16
